// ===== cause_core_model.sv
`timescale 1ns/1ps
`default_nettype none

module cause_core_model
	import reset_cause_pkg::*;
(
	// clock and state
	input wire logic clk_in,
	input wire logic sleeping_in,
	// causes and core
	output logic [7:0] cause_out,
	output logic [PC_W-1:0] pc_out,
	output logic done_out
);
	logic [PC_W-1:0] last_pc;

	initial begin
		cause_out = 8'h00;
		pc_out = 15'h0100;
		done_out = 1'b0;
	end

	// pc stands still while asleep, as a halted core would
	always @(posedge clk_in) begin
		if (!sleeping_in) begin
			pc_out <= pc_out + 15'h0001;
		end
	end

	// one-cycle pulse; several causes may coincide
	task automatic fire(input logic [7:0] m, input logic d);
		@(posedge clk_in);
		cause_out <= m;
		done_out <= d;
		@(posedge clk_in);
		last_pc = pc_out;
		cause_out <= 8'h00;
		done_out <= 1'b0;
	endtask
endmodule

`default_nettype wire

// ===== reset_cause_avs.sv
`timescale 1ns/1ps
`default_nettype none

module reset_cause_avs
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// bus side
	input wire logic [3:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [31:0] writedata_in,
	input wire logic [3:0] byteenable_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	// register side
	input wire logic [7:0] rdata_in,
	output logic wr_en_out,
	output logic [3:0] wr_addr_out,
	output logic [7:0] wr_data_out
);

	typedef struct packed {
		logic wait_flag;
		logic [7:0] rdata;
	} avs_state_t;

	avs_state_t s_reg;
	avs_state_t s_next;

	// ****************************************************************
	// one wait state, then the request is taken
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		s_next.wait_flag = ~((read_in | write_in) & s_reg.wait_flag);
		if (read_in && s_reg.wait_flag) begin
			s_next.rdata = rdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_reg <= '{wait_flag: 1'b1, rdata: 8'h00};
		end else begin
			s_reg <= s_next;
		end
	end

	assign waitrequest_out = s_reg.wait_flag;
	assign readdata_out = {24'h00_0000, s_reg.rdata};
	assign wr_en_out = write_in & ~s_reg.wait_flag & byteenable_in[0];
	assign wr_addr_out = address_in;
	assign wr_data_out = writedata_in[7:0];

endmodule

`default_nettype wire

// ===== reset_cause_decode.sv
`timescale 1ns/1ps
`default_nettype none

module reset_cause_decode
	import reset_cause_pkg::*;
(
	// reset and wake causes
	input wire logic brownout_in,
	input wire logic wdt_expire_in,
	input wire logic int_wake_in,
	input wire logic ext_pin_in,
	input wire logic reset_instr_in,
	input wire logic stack_ovf_in,
	input wire logic stack_unf_in,
	input wire logic sleep_enter_in,
	// context
	input wire logic sleeping_in,
	input wire logic stack_reset_enable_in,
	// flag updates
	output logic [7:0] power_control_clr_out,
	output logic [7:0] power_control_set_out,
	output logic [1:0] st_clr_out,
	output logic [1:0] st_set_out,
	output logic do_reset_out,
	output logic do_wake_out,
	output logic int_wake_out,
	output logic go_sleep_out
);

	// ****************************************************************
	// every asserted cause adds its own updates
	// ****************************************************************
	always_comb begin
		power_control_clr_out = '0;
		power_control_set_out = '0;
		st_clr_out = '0;
		st_set_out = '0;
		do_reset_out = 1'b0;
		do_wake_out = 1'b0;
		int_wake_out = 1'b0;
		go_sleep_out = 1'b0;
		if (brownout_in) begin
			power_control_clr_out[BROWNOUT_BIT] = 1'b1;
			power_control_clr_out[STACK_OVERFLOW_BIT] = 1'b1;
			power_control_clr_out[STACK_UNDERFLOW_BIT] = 1'b1;
			power_control_set_out[EXT_RESET_PIN_BIT] = 1'b1;
			power_control_set_out[RESET_INSTR_BIT] = 1'b1;
			st_set_out = 2'h3;
			do_reset_out = 1'b1;
		end
		if (wdt_expire_in) begin
			st_clr_out[ST_EXPIRED] = 1'b1;
			if (sleeping_in) begin
				st_clr_out[ST_SLEEP] = 1'b1;
				do_wake_out = 1'b1;
			end else begin
				power_control_clr_out[WATCHDOG_RESET_BIT] = 1'b1;
				do_reset_out = 1'b1;
			end
		end
		if (int_wake_in && sleeping_in) begin
			st_set_out[ST_EXPIRED] = 1'b1;
			st_clr_out[ST_SLEEP] = 1'b1;
			do_wake_out = 1'b1;
			int_wake_out = 1'b1;
		end
		if (ext_pin_in) begin
			power_control_clr_out[EXT_RESET_PIN_BIT] = 1'b1;
			do_reset_out = 1'b1;
			if (sleeping_in) begin
				st_set_out[ST_EXPIRED] = 1'b1;
				st_clr_out[ST_SLEEP] = 1'b1;
			end
		end
		if (reset_instr_in) begin
			power_control_clr_out[RESET_INSTR_BIT] = 1'b1;
			do_reset_out = 1'b1;
		end
		if (stack_reset_enable_in && stack_ovf_in) begin
			power_control_set_out[STACK_OVERFLOW_BIT] = 1'b1;
			do_reset_out = 1'b1;
		end
		if (stack_reset_enable_in && stack_unf_in) begin
			power_control_set_out[STACK_UNDERFLOW_BIT] = 1'b1;
			do_reset_out = 1'b1;
		end
		if (sleep_enter_in && !sleeping_in) begin
			st_set_out[ST_EXPIRED] = 1'b1;
			st_clr_out[ST_SLEEP] = 1'b1;
			go_sleep_out = 1'b1;
		end
	end

endmodule

`default_nettype wire

// ===== reset_cause_flags.sv
`timescale 1ns/1ps
`default_nettype none

module reset_cause_flags
	import reset_cause_pkg::*;
#(
	parameter int PC_WIDTH = PC_W
)
(
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// register bus
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// reset and wake causes, one-cycle pulses
	input wire logic BROWNOUT_IN,
	input wire logic WDT_EXPIRE_IN,
	input wire logic INT_WAKE_IN,
	input wire logic EXTERNAL_RESET_PIN_IN,
	input wire logic RESET_INSTR_IN,
	input wire logic STACK_OVF_IN,
	input wire logic STACK_UNF_IN,
	input wire logic SLEEP_ENTER_IN,
	// processor core
	input wire logic [PC_WIDTH-1:0] CORE_PC_IN,
	input wire logic CORE_INSTR_DONE_IN,
	output logic CORE_RESET_OUT,
	output logic RESTART_VALID_OUT,
	output logic [PC_WIDTH-1:0] RESTART_PC_OUT,
	output logic VECTOR_VALID_OUT,
	output logic [PC_WIDTH-1:0] VECTOR_PC_OUT,
	output logic [PC_WIDTH-1:0] RETURN_PC_OUT,
	output logic SLEEPING_OUT
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0] power_control;
		logic [1:0] status_flags;
		logic [1:0] config_bits;
		logic sleeping;
		logic core_reset;
		logic restart_valid;
		logic [PC_WIDTH-1:0] restart_pc;
		logic vector_pending;
		logic vector_valid;
		logic [PC_WIDTH-1:0] return_pc;
		logic [PC_WIDTH-1:0] vector_pc;
	} flags_state_t;

	flags_state_t s_reg;
	flags_state_t s_next;

	logic [7:0] power_control_clr;
	logic [7:0] power_control_set;
	logic [1:0] st_clr;
	logic [1:0] st_set;
	logic do_reset;
	logic do_wake;
	logic int_wake;
	logic go_sleep;
	logic wr_en;
	logic [3:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rdata;
	logic [7:0] fw_clr;
	logic [7:0] fw_set;
	logic [7:0] power_control_fw;
	logic [1:0] st_hw;
	logic [PC_WIDTH-1:0] pc_next_instr;
	logic [7:0] power_control_next;
	logic [7:0] status_view;
	logic wr_power_control;
	logic wr_config;

	// ****************************************************************
	// cause decoding
	// ****************************************************************
	reset_cause_decode u_decode (
		.brownout_in(BROWNOUT_IN),
		.wdt_expire_in(WDT_EXPIRE_IN),
		.int_wake_in(INT_WAKE_IN),
		.ext_pin_in(EXTERNAL_RESET_PIN_IN),
		.reset_instr_in(RESET_INSTR_IN),
		.stack_ovf_in(STACK_OVF_IN),
		.stack_unf_in(STACK_UNF_IN),
		.sleep_enter_in(SLEEP_ENTER_IN),
		.sleeping_in(s_reg.sleeping),
		.stack_reset_enable_in(s_reg.config_bits[STACK_RESET_ENABLE_BIT]),
		.power_control_clr_out(power_control_clr),
		.power_control_set_out(power_control_set),
		.st_clr_out(st_clr),
		.st_set_out(st_set),
		.do_reset_out(do_reset),
		.do_wake_out(do_wake),
		.int_wake_out(int_wake),
		.go_sleep_out(go_sleep)
	);

	// ****************************************************************
	// bus slave
	// ****************************************************************
	reset_cause_avs u_avs (
		.clk_in(SYS_CLK_IN),
		.rst_n_in(RST_N_IN),
		.address_in(AVS_ADDRESS_IN),
		.read_in(AVS_READ_IN),
		.write_in(AVS_WRITE_IN),
		.writedata_in(AVS_WRITEDATA_IN),
		.byteenable_in(AVS_BYTEENABLE_IN),
		.readdata_out(AVS_READDATA_OUT),
		.waitrequest_out(AVS_WAITREQUEST_OUT),
		.rdata_in(rdata),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data)
	);

	// ****************************************************************
	// core status as firmware sees it
	// ****************************************************************
	always_comb begin
		// only the two power flags live here; the rest reads zero
		status_view = 8'h00;
		status_view[WATCHDOG_EXPIRED_BIT] = s_reg.status_flags[ST_EXPIRED];
		status_view[SLEEP_ENTERED_BIT] = s_reg.status_flags[ST_SLEEP];
	end

	// ****************************************************************
	// read mux; unmapped addresses read zero
	// ****************************************************************
	always_comb begin
		rdata = 8'h00;
		case (AVS_ADDRESS_IN)
			POWER_CONTROL_OFS: begin
				rdata = s_reg.power_control & POWER_CONTROL_MASK;
			end
			CORE_STATUS_OFS: begin
				rdata = status_view;
			end
			CONFIG_OFS: begin
				rdata = {6'h00, s_reg.config_bits};
			end
			default: begin
				rdata = 8'h00;
			end
		endcase
	end

	// ****************************************************************
	// write decode; the bus slave already gates byte lane 0
	// ****************************************************************
	assign wr_power_control = wr_en && (wr_addr == POWER_CONTROL_OFS);
	assign wr_config = wr_en && (wr_addr == CONFIG_OFS);

	// ****************************************************************
	// firmware clears of the stack flags; writing one leaves them
	// ****************************************************************
	always_comb begin
		fw_clr = 8'h00;
		if (wr_power_control) begin
			fw_clr[STACK_OVERFLOW_BIT] = ~wr_data[STACK_OVERFLOW_BIT];
			fw_clr[STACK_UNDERFLOW_BIT] = ~wr_data[STACK_UNDERFLOW_BIT];
		end
	end

	// ****************************************************************
	// firmware sets of the cause flags; writing zero leaves them
	// ****************************************************************
	always_comb begin
		fw_set = 8'h00;
		if (wr_power_control) begin
			fw_set[WATCHDOG_RESET_BIT] = wr_data[WATCHDOG_RESET_BIT];
			fw_set[EXT_RESET_PIN_BIT] = wr_data[EXT_RESET_PIN_BIT];
			fw_set[RESET_INSTR_BIT] = wr_data[RESET_INSTR_BIT];
			// firmware marks a power-on or brown-out as seen
			fw_set[POWER_ON_BIT] = wr_data[POWER_ON_BIT];
			fw_set[BROWNOUT_BIT] = wr_data[BROWNOUT_BIT];
		end
	end

	// ****************************************************************
	// firmware edits applied to the stored power control value
	// ****************************************************************
	assign power_control_fw = (s_reg.power_control & ~fw_clr) | fw_set;

	// ****************************************************************
	// per bit: a hardware event in the same cycle beats firmware, a
	// clear beats a set, and the unused bit stays zero
	// ****************************************************************
	for (genvar i = 0; i < 8; i++) begin : g_power_control_bit
		assign power_control_next[i] = POWER_CONTROL_MASK[i] & ~power_control_clr[i]
			& (power_control_set[i] | power_control_fw[i]);
	end

	// ****************************************************************
	// status flags: only hardware writes them
	// ****************************************************************
	for (genvar i = 0; i < 2; i++) begin : g_status_bit
		assign st_hw[i] = ~st_clr[i]
			& (st_set[i] | s_reg.status_flags[i]);
	end

	// ****************************************************************
	// address of the instruction after the current one
	// ****************************************************************
	assign pc_next_instr = CORE_PC_IN + {{(PC_WIDTH-1){1'b0}}, 1'b1};

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		s_next = s_reg;
		s_next.power_control = power_control_next;
		s_next.status_flags = st_hw;
		// config belongs to firmware alone; no event touches it
		if (wr_config) begin
			s_next.config_bits = wr_data[1:0];
		end
		// pulses stand for one cycle; the core latches what it needs
		s_next.core_reset = do_reset;
		s_next.restart_valid = do_reset | do_wake;
		s_next.vector_valid = 1'b0;
		if (go_sleep) begin
			s_next.sleeping = 1'b1;
		end
		if (do_reset) begin
			// any reset outranks a wake in the same cycle
			s_next.sleeping = 1'b0;
			s_next.restart_pc = RESTART_ADDR;
			s_next.vector_pending = 1'b0;
		end else if (do_wake) begin
			s_next.sleeping = 1'b0;
			s_next.restart_pc = pc_next_instr;
			s_next.vector_pending = int_wake &
				s_reg.config_bits[GLOBAL_INT_ENABLE_BIT];
		end else if (s_reg.vector_pending && CORE_INSTR_DONE_IN) begin
			// after the wake instruction, push return and vector
			s_next.vector_pending = 1'b0;
			s_next.vector_valid = 1'b1;
			s_next.return_pc = pc_next_instr;
		end
	end

	// ****************************************************************
	// registers; power-on reset loads the power-on values
	// ****************************************************************
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_reg.power_control <= POWER_CONTROL_RST;
			s_reg.status_flags <= STATUS_FLAGS_RST;
			s_reg.config_bits <= CONFIG_RST;
			s_reg.sleeping <= 1'b0;
			s_reg.core_reset <= 1'b0;
			s_reg.restart_valid <= 1'b0;
			s_reg.restart_pc <= RESTART_ADDR;
			s_reg.vector_pending <= 1'b0;
			s_reg.vector_valid <= 1'b0;
			s_reg.return_pc <= RESTART_ADDR;
			s_reg.vector_pc <= INT_VECTOR_ADDR;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign CORE_RESET_OUT = s_reg.core_reset;
	assign RESTART_VALID_OUT = s_reg.restart_valid;
	assign RESTART_PC_OUT = s_reg.restart_pc;
	assign VECTOR_VALID_OUT = s_reg.vector_valid;
	assign VECTOR_PC_OUT = s_reg.vector_pc;
	assign RETURN_PC_OUT = s_reg.return_pc;
	assign SLEEPING_OUT = s_reg.sleeping;

endmodule

`default_nettype wire

// ===== reset_cause_flags_checker.sv
`timescale 1ns/1ps
`default_nettype none

module reset_cause_flags_checker
	import reset_cause_pkg::*;
#(
	parameter int PC_WIDTH = PC_W
)
(
	// clock and reset
	input wire logic SYS_CLK_IN,
	input wire logic RST_N_IN,
	// register bus
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	input wire logic [31:0] AVS_READDATA_OUT,
	input wire logic AVS_WAITREQUEST_OUT,
	// causes
	input wire logic BROWNOUT_IN,
	input wire logic WDT_EXPIRE_IN,
	input wire logic INT_WAKE_IN,
	input wire logic EXTERNAL_RESET_PIN_IN,
	input wire logic RESET_INSTR_IN,
	input wire logic STACK_OVF_IN,
	input wire logic STACK_UNF_IN,
	input wire logic SLEEP_ENTER_IN,
	// core
	input wire logic [PC_WIDTH-1:0] CORE_PC_IN,
	input wire logic CORE_INSTR_DONE_IN,
	input wire logic CORE_RESET_OUT,
	input wire logic RESTART_VALID_OUT,
	input wire logic [PC_WIDTH-1:0] RESTART_PC_OUT,
	input wire logic VECTOR_VALID_OUT,
	input wire logic [PC_WIDTH-1:0] VECTOR_PC_OUT,
	input wire logic [PC_WIDTH-1:0] RETURN_PC_OUT,
	input wire logic SLEEPING_OUT
);
	// ****************************************************************
	// properties
	// ****************************************************************
	logic any_rst;
	assign any_rst = BROWNOUT_IN | EXTERNAL_RESET_PIN_IN | RESET_INSTR_IN
		| STACK_OVF_IN | STACK_UNF_IN;
	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);

	wdt_run_reset_a: assert property (WDT_EXPIRE_IN && !SLEEPING_OUT |=>
		CORE_RESET_OUT && RESTART_VALID_OUT && RESTART_PC_OUT == '0)
		else $error("watchdog reset while running not taken");
	wdt_wake_a: assert property (WDT_EXPIRE_IN && SLEEPING_OUT
		&& !any_rst |=> !CORE_RESET_OUT && RESTART_VALID_OUT && !SLEEPING_OUT
		&& RESTART_PC_OUT == PC_WIDTH'($past(CORE_PC_IN) + 1))
		else $error("watchdog wake address wrong");
	int_wake_a: assert property (INT_WAKE_IN && SLEEPING_OUT && !any_rst
		&& !WDT_EXPIRE_IN |=> !CORE_RESET_OUT && RESTART_VALID_OUT
		&& RESTART_PC_OUT == PC_WIDTH'($past(CORE_PC_IN) + 1))
		else $error("interrupt wake address wrong");
	int_ignored_a: assert property (INT_WAKE_IN && !SLEEPING_OUT
		&& !any_rst && !WDT_EXPIRE_IN && !SLEEP_ENTER_IN |=> !RESTART_VALID_OUT)
		else $error("interrupt wake while running restarted core");
	pin_reset_a: assert property (EXTERNAL_RESET_PIN_IN |=>
		CORE_RESET_OUT && RESTART_PC_OUT == '0 && !SLEEPING_OUT)
		else $error("pin reset not restarting at zero");
	instr_reset_a: assert property (RESET_INSTR_IN || BROWNOUT_IN |=>
		CORE_RESET_OUT ##0 RESTART_VALID_OUT ##0 RESTART_PC_OUT == '0)
		else $error("instruction or brown-out reset not taken");
	vector_jump_a: assert property (VECTOR_VALID_OUT |->
		VECTOR_PC_OUT == PC_WIDTH'(INT_VECTOR_ADDR)
		&& RETURN_PC_OUT == PC_WIDTH'($past(CORE_PC_IN) + 1))
		else $error("vector or return address wrong");
	unused_bit_a: assert property (AVS_READ_IN
		&& !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == POWER_CONTROL_OFS |->
		AVS_READDATA_OUT[UNUSED_BIT] == 1'b0 && AVS_READDATA_OUT[31:8] == '0)
		else $error("power control unused bits not zero");

	cover property (WDT_EXPIRE_IN && SLEEPING_OUT);
	cover property (VECTOR_VALID_OUT);
	cover property (EXTERNAL_RESET_PIN_IN && SLEEPING_OUT);
endmodule

bind reset_cause_flags reset_cause_flags_checker #(.PC_WIDTH(PC_WIDTH)) u_chk (
	.SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN),
	.AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
	.AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
	.AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
	.AVS_READDATA_OUT(AVS_READDATA_OUT),
	.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
	.BROWNOUT_IN(BROWNOUT_IN), .WDT_EXPIRE_IN(WDT_EXPIRE_IN),
	.INT_WAKE_IN(INT_WAKE_IN), .EXTERNAL_RESET_PIN_IN(EXTERNAL_RESET_PIN_IN),
	.RESET_INSTR_IN(RESET_INSTR_IN), .STACK_OVF_IN(STACK_OVF_IN),
	.STACK_UNF_IN(STACK_UNF_IN), .SLEEP_ENTER_IN(SLEEP_ENTER_IN),
	.CORE_PC_IN(CORE_PC_IN), .CORE_INSTR_DONE_IN(CORE_INSTR_DONE_IN),
	.CORE_RESET_OUT(CORE_RESET_OUT), .RESTART_VALID_OUT(RESTART_VALID_OUT),
	.RESTART_PC_OUT(RESTART_PC_OUT), .VECTOR_VALID_OUT(VECTOR_VALID_OUT),
	.VECTOR_PC_OUT(VECTOR_PC_OUT), .RETURN_PC_OUT(RETURN_PC_OUT),
	.SLEEPING_OUT(SLEEPING_OUT)
);

`default_nettype wire

// ===== reset_cause_pkg.sv
package reset_cause_pkg;

	// ****************************************************************
	// register map, byte addresses on the bus
	// ****************************************************************
	localparam logic [3:0] POWER_CONTROL_OFS = 4'h0;
	localparam logic [3:0] CORE_STATUS_OFS = 4'h4;
	localparam logic [3:0] CONFIG_OFS = 4'h8;

	// ****************************************************************
	// power control field positions
	// ****************************************************************
	localparam int STACK_OVERFLOW_BIT = 7;
	localparam int STACK_UNDERFLOW_BIT = 6;
	localparam int UNUSED_BIT = 5;
	localparam int WATCHDOG_RESET_BIT = 4;
	localparam int EXT_RESET_PIN_BIT = 3;
	localparam int RESET_INSTR_BIT = 2;
	localparam int POWER_ON_BIT = 1;
	localparam int BROWNOUT_BIT = 0;

	// ****************************************************************
	// core status field positions
	// ****************************************************************
	localparam int WATCHDOG_EXPIRED_BIT = 4;
	localparam int SLEEP_ENTERED_BIT = 3;
	// index into the two-bit hardware masks
	localparam int ST_EXPIRED = 1;
	localparam int ST_SLEEP = 0;

	// ****************************************************************
	// config field positions
	// ****************************************************************
	localparam int STACK_RESET_ENABLE_BIT = 0;
	localparam int GLOBAL_INT_ENABLE_BIT = 1;

	// ****************************************************************
	// values after power-on reset, and the power control bit mask
	// ****************************************************************
	localparam logic [7:0] POWER_CONTROL_RST = 8'h1C;
	localparam logic [7:0] POWER_CONTROL_MASK = 8'hDF;
	localparam logic [1:0] STATUS_FLAGS_RST = 2'h3;
	localparam logic [1:0] CONFIG_RST = 2'h0;

	// ****************************************************************
	// program counter
	// ****************************************************************
	localparam int PC_W = 15;
	localparam logic [PC_W-1:0] RESTART_ADDR = 15'h0000;
	localparam logic [PC_W-1:0] INT_VECTOR_ADDR = 15'h0004;

endpackage

// ===== test_reset_cause_flags.sv
`timescale 1ns/1ps
`default_nettype none

module test_reset_cause_flags
	import reset_cause_pkg::*;
;
	localparam logic [7:0] BO = 8'h80, WD = 8'h40, IW = 8'h20, PN = 8'h10;
	localparam logic [7:0] INS = 8'h08, OV = 8'h04, UN = 8'h02, SL = 8'h01;
	localparam logic [3:0] PCR = POWER_CONTROL_OFS, STR = CORE_STATUS_OFS;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr, be;
	logic read, write, waitreq, done, rst_o, rv, vv, sleeping;
	logic [31:0] wdata, rdata, q;
	logic [7:0] cause;
	logic [PC_W-1:0] pc, rpc, vpc, retpc;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	reset_cause_flags u_reset_cause_flags (
		.SYS_CLK_IN(clk), .RST_N_IN(rst_n), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(read), .AVS_WRITE_IN(write), .AVS_WRITEDATA_IN(wdata),
		.AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata),
		.AVS_WAITREQUEST_OUT(waitreq), .BROWNOUT_IN(cause[7]),
		.WDT_EXPIRE_IN(cause[6]), .INT_WAKE_IN(cause[5]),
		.EXTERNAL_RESET_PIN_IN(cause[4]), .RESET_INSTR_IN(cause[3]),
		.STACK_OVF_IN(cause[2]), .STACK_UNF_IN(cause[1]),
		.SLEEP_ENTER_IN(cause[0]), .CORE_PC_IN(pc), .CORE_INSTR_DONE_IN(done),
		.CORE_RESET_OUT(rst_o), .RESTART_VALID_OUT(rv), .RESTART_PC_OUT(rpc),
		.VECTOR_VALID_OUT(vv), .VECTOR_PC_OUT(vpc), .RETURN_PC_OUT(retpc),
		.SLEEPING_OUT(sleeping)
	);

	cause_core_model core (
		.clk_in(clk), .sleeping_in(sleeping), .cause_out(cause),
		.pc_out(pc), .done_out(done)
	);

	// ****************************************************************
	// bus access and checking
	// ****************************************************************
	task automatic test_done;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [3:0] b);
		@(posedge clk);
		addr <= a;
		wdata <= {24'h00_0000, d};
		be <= b;
		if (w) begin
			write <= 1'b1;
		end else begin
			read <= 1'b1;
		end
		do @(posedge clk); while (waitreq !== 1'b0);
		q = rdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hF);
		cmp(q, {24'h00_0000, e});
	endtask

	// core-side outputs one step after the edge that took the event
	task automatic out_chk(input logic r, input logic [PC_W-1:0] p);
		#1;
		cmp({14'h0000, rst_o, sleeping, rv, rpc}, {14'h0000, r, 1'b0, 1'b1, p});
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			$display("wrong value at %0t: timeout", $time);
			test_done;
		end
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		addr = 4'h0;
		read = 1'b0;
		write = 1'b0;
		wdata = 32'h0000_0000;
		be = 4'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(PCR, 8'h1C);
		rd(STR, 8'h18);
		rd(CONFIG_OFS, 8'h00);
		wr(PCR, 8'hFF);
		rd(PCR, 8'h1F);
		wr(PCR, 8'h00);
		rd(PCR, 8'h1F);
		core.fire(BO, 1'b0);
		rd(PCR, 8'h1E);
		wr(PCR, 8'h01);
		core.fire(WD, 1'b0);
		out_chk(1'b1, RESTART_ADDR);
		rd(PCR, 8'h0F);
		rd(STR, 8'h08);
		core.fire(PN, 1'b0);
		rd(PCR, 8'h07);
		rd(STR, 8'h08);
		core.fire(INS, 1'b0);
		rd(PCR, 8'h03);
		wr(PCR, 8'h1F);
		core.fire(OV, 1'b0);
		rd(PCR, 8'h1F);
		wr(CONFIG_OFS, 8'h03);
		core.fire(OV, 1'b0);
		rd(PCR, 8'h9F);
		core.fire(UN, 1'b0);
		rd(PCR, 8'hDF);
		wr(PCR, 8'h3F);
		rd(PCR, 8'h1F);
		core.fire(SL, 1'b0);
		rd(STR, 8'h10);
		core.fire(WD, 1'b0);
		out_chk(1'b0, core.last_pc + 15'h0001);
		rd(STR, 8'h00);
		rd(PCR, 8'h1F);
		core.fire(SL, 1'b0);
		core.fire(IW, 1'b0);
		out_chk(1'b0, core.last_pc + 15'h0001);
		core.fire(8'h00, 1'b1);
		#1;
		cmp({vv, vpc, retpc, 1'b0},
			{1'b1, INT_VECTOR_ADDR, core.last_pc + 15'h0001, 1'b0});
		rd(STR, 8'h10);
		core.fire(SL, 1'b0);
		core.fire(PN, 1'b0);
		out_chk(1'b1, RESTART_ADDR);
		rd(PCR, 8'h17);
		rd(STR, 8'h10);
		wr(PCR, 8'h1F);
		core.fire(BO | PN | INS | OV, 1'b0);
		rd(PCR, 8'h12);
		rd(STR, 8'h18);
		wr(STR, 8'h00);
		rd(STR, 8'h18);
		bus(1'b1, PCR, 8'hFF, 4'hE);
		rd(PCR, 8'h12);
		wr(4'hC, 8'hFF);
		rd(4'hC, 8'h00);
		// interrupts off: a wake resumes but never vectors
		wr(CONFIG_OFS, 8'h01);
		core.fire(IW, 1'b0);
		#1;
		cmp({16'h0000, 15'h0000, rv}, 32'h0000_0000);
		rd(STR, 8'h18);
		core.fire(SL, 1'b0);
		core.fire(IW, 1'b0);
		out_chk(1'b0, core.last_pc + 15'h0001);
		core.fire(8'h00, 1'b1);
		#1;
		cmp({16'h0000, 15'h0000, vv}, 32'h0000_0000);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(PCR, 8'h1C);
		rd(CONFIG_OFS, 8'h00);
		test_done;
	end
endmodule

`default_nettype wire
